// File: rtl/fpd_pkg.sv
package fpd_pkg;

	// Bus cycle type codes
	localparam logic [2:0]  CODE_WRITE      = 3'h1;
	localparam logic [2:0]  CODE_READ       = 3'h5;

	// Command data bytes
	localparam logic [7:0]  DATA_UNLOCK_1   = 8'hAA;
	localparam logic [7:0]  DATA_UNLOCK_2   = 8'h55;
	localparam logic [7:0]  DATA_PLOCK_ENT  = 8'h50;
	localparam logic [7:0]  DATA_DPROT_ENT  = 8'hE0;
	localparam logic [7:0]  DATA_ECC_ENT    = 8'h75;
	localparam logic [7:0]  DATA_PROG       = 8'hA0;
	localparam logic [7:0]  DATA_ZERO       = 8'h00;
	localparam logic [7:0]  DATA_ONE        = 8'h01;
	localparam logic [7:0]  DATA_QUERY      = 8'h60;
	localparam logic [7:0]  DATA_EXIT       = 8'hF0;

	// Unlock addresses, low 12 bits only
	localparam int          UNLOCK_BITS     = 12;
	localparam logic [11:0] ADDR_UNLOCK_1   = 12'h555;
	localparam logic [11:0] ADDR_UNLOCK_2   = 12'h2AA;

	// Trap and counter selects in the low two address bits
	localparam logic [1:0]  SEL_TRAP_LOW    = 2'h0;
	localparam logic [1:0]  SEL_TRAP_HIGH   = 2'h1;
	localparam logic [1:0]  SEL_COUNT       = 2'h2;

	// Protection status word fields
	localparam int          STS_PROT_BIT    = 0;
	localparam int          STS_LOCK_BIT    = 1;

	// Avalon register byte offsets
	localparam logic [7:0]  REG_STATUS      = 8'h00;
	localparam logic [7:0]  REG_LOCK        = 8'h04;
	localparam logic [7:0]  REG_TRAP        = 8'h08;
	localparam logic [7:0]  REG_COUNT       = 8'h0C;
	localparam logic [7:0]  REG_UNIT_STS    = 8'h10;
	localparam logic [7:0]  REG_PROT        = 8'h14;

	// Status register fields
	localparam int          STATUS_MODE_LSB = 0;
	localparam int          STATUS_LOCK_BIT = 2;

	// Reset values
	localparam logic        RST_LOCK        = 1'b1;
	localparam logic        RST_PROT        = 1'b1;
	localparam logic [31:0] RST_TRAP        = 32'h00000000;
	localparam logic [15:0] RST_COUNT       = 16'h0000;
	localparam logic [15:0] RST_UNIT_STS    = 16'h0000;

	typedef enum logic [1:0] {
		MODE_NONE,
		MODE_PLOCK,
		MODE_DPROT,
		MODE_ECC
	} fpd_mode_type;

	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_UNLK1,
		SEQ_UNLK2,
		SEQ_PROG,
		SEQ_QUERY
	} fpd_seq_type;

endpackage

// File: rtl/fpd_link_end.sv
`timescale 1ns/1ps
module fpd_link_end #(
	parameter int ADDR_W = 22
) (
	input  wire logic              link_clk,
	input  wire logic              rst,
	input  wire logic              link_valid,
	input  wire logic [2:0]        link_code,
	input  wire logic [1:0]        link_die,
	input  wire logic [ADDR_W-1:0] link_addr,
	input  wire logic [7:0]        link_wdata,
	input  wire logic              ack_tgl,
	input  wire logic [15:0]       rsp_data,
	output logic                   link_ready,
	output logic [15:0]            link_rdata,
	output logic                   link_rvalid,
	output logic                   req_tgl,
	output logic [2:0]             cap_code,
	output logic [1:0]             cap_die,
	output logic [ADDR_W-1:0]      cap_addr,
	output logic [7:0]             cap_wdata
);

	typedef struct packed {
		logic              ready;
		logic [15:0]       rdata;
		logic              rvalid;
		logic              req_tgl;
		logic [2:0]        code;
		logic [1:0]        die;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
		logic              ack_s1;
		logic              ack_s2;
		logic              ack_prev;
	} fpd_link_state_type;

	fpd_link_state_type s;
	fpd_link_state_type n;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = s;
		n.rvalid = 1'b0;
		n.ack_s1 = ack_tgl;
		n.ack_s2 = s.ack_s1;
		n.ack_prev = s.ack_s2;
		// One cycle in flight; fields hold still until answered
		if (link_valid && s.ready) begin
			n.ready = 1'b0;
			n.req_tgl = ~s.req_tgl;
			n.code = link_code;
			n.die = link_die;
			n.addr = link_addr;
			n.wdata = link_wdata;
		end
		if (s.ack_s2 != s.ack_prev) begin
			n.ready = 1'b1;
			n.rdata = rsp_data;
			n.rvalid = (s.code == fpd_pkg::CODE_READ);
		end
	end

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			s <= '{ready: 1'b1, default: '0};
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign link_ready = s.ready;
	assign link_rdata = s.rdata;
	assign link_rvalid = s.rvalid;
	assign req_tgl = s.req_tgl;
	assign cap_code = s.code;
	assign cap_die = s.die;
	assign cap_addr = s.addr;
	assign cap_wdata = s.wdata;

endmodule

// File: rtl/fpd_cmd_decoder.sv
// Functional notes
// - Write cycles carry code 001b; read cycles returning data carry 101b.
// - AAh@555h, 55h@2AAh, 50h@555h enters persistent-lock mode; low 12 bits decoded.
// - In persistent-lock mode, A0h then 00h anywhere clears the lock bit.
// - In persistent-lock mode, a read anywhere returns the lock state word.
// - A write of F0h anywhere ends the active protection or ECC mode.
// - Same unlock pair then E0h@555h enters dynamic-protection mode.
// - In dynamic mode, A0h then 00h at a sector clears its protect bit.
// - In dynamic mode, A0h then 01h at a sector sets its protect bit.
// - In dynamic mode, a read at a sector returns its protect bit word.
// - Outside ECC mode, 60h then a read at a sector returns that sector's protection status.
// - Same unlock pair then 75h@555h enters ECC mode.
// - In ECC mode, a read at an array address returns unit ECC status.
// - In ECC mode, 60h then read with low bits 00b gives trap low half.
// - In ECC mode, 60h then read with low bits 01b gives trap high half.
// - In ECC mode, 60h then read with low bits 10b gives error count.
`timescale 1ns/1ps
module fpd_cmd_decoder #(
	parameter int         ADDR_W  = 22,
	parameter int         SEC_LSB = 17,
	parameter logic [1:0] DIE_SEL = 2'h0
) (
	input  wire logic              REF_CLK,
	input  wire logic              RST,
	input  wire logic [7:0]        AV_ADDRESS,
	input  wire logic              AV_READ,
	input  wire logic              AV_WRITE,
	input  wire logic [31:0]       AV_WRITEDATA,
	input  wire logic [3:0]        AV_BYTEENABLE,
	output logic [31:0]            AV_READDATA,
	output logic                   AV_WAITREQUEST,
	input  wire logic              LINK_CLK,
	input  wire logic              LINK_VALID,
	input  wire logic [2:0]        LINK_CODE,
	input  wire logic [1:0]        LINK_DIE,
	input  wire logic [ADDR_W-1:0] LINK_ADDR,
	input  wire logic [7:0]        LINK_WDATA,
	output logic                   LINK_READY,
	output logic [15:0]            LINK_RDATA,
	output logic                   LINK_RVALID
);

	// Sector index taken from the top address bits
	localparam int SEC_W   = ADDR_W - SEC_LSB;
	localparam int NUM_SEC = 2 ** SEC_W;

	// Whole state of the block, registered once per clock
	typedef struct packed {
		fpd_pkg::fpd_mode_type mode;
		fpd_pkg::fpd_seq_type  seq;
		logic                  lock;
		logic [NUM_SEC-1:0]    prot;
		logic [31:0]           trap;
		logic [15:0]           count;
		logic [15:0]           unit_sts;
		logic                  req_s1;
		logic                  req_s2;
		logic                  req_prev;
		logic                  ack_tgl;
		logic [15:0]           rsp_data;
		logic [31:0]           av_rdata;
		logic                  av_wait;
	} fpd_state_type;

	fpd_state_type     s;
	fpd_state_type     n;
	// Captured link cycle, steady while a cycle is in flight
	logic              req_tgl;
	logic [2:0]        cap_code;
	logic [1:0]        cap_die;
	logic [ADDR_W-1:0] cap_addr;
	logic [7:0]        cap_wdata;
	logic [SEC_W-1:0]  sector;
	logic [11:0]       low_addr;
	logic [15:0]       idle_read;
	logic [15:0]       status_word;
	logic [31:0]       be_mask;
	logic [31:0]       reg_read;
	logic [31:0]       prot_word;
	logic              new_cycle;

	////////////////////////////////////////////////////////////////////////////////
	// Link-clock end of the handshake
	fpd_link_end #(
		.ADDR_W(ADDR_W)
	) u_link (
		.link_clk   (LINK_CLK),
		.rst        (RST),
		.link_valid (LINK_VALID),
		.link_code  (LINK_CODE),
		.link_die   (LINK_DIE),
		.link_addr  (LINK_ADDR),
		.link_wdata (LINK_WDATA),
		.ack_tgl    (s.ack_tgl),
		.rsp_data   (s.rsp_data),
		.link_ready (LINK_READY),
		.link_rdata (LINK_RDATA),
		.link_rvalid(LINK_RVALID),
		.req_tgl    (req_tgl),
		.cap_code   (cap_code),
		.cap_die    (cap_die),
		.cap_addr   (cap_addr),
		.cap_wdata  (cap_wdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Address fields and read answers
	assign sector = cap_addr[SEC_LSB +: SEC_W];
	assign low_addr = cap_addr[fpd_pkg::UNLOCK_BITS-1:0];
	// One-cycle pulse per link cycle, after the two-stage sync
	assign new_cycle = s.req_s2 != s.req_prev;

	// Plain-read answer per mode, and the query status word
	always_comb begin
		status_word = '0;
		status_word[fpd_pkg::STS_PROT_BIT] = s.prot[sector];
		status_word[fpd_pkg::STS_LOCK_BIT] = s.lock;
		case (s.mode)
			fpd_pkg::MODE_PLOCK: begin
				idle_read = {15'h0000, s.lock};
			end
			fpd_pkg::MODE_DPROT: begin
				idle_read = {15'h0000, s.prot[sector]};
			end
			fpd_pkg::MODE_ECC: begin
				idle_read = s.unit_sts;
			end
			default: begin
				idle_read = 16'h0000;
			end
		endcase
	end

	// Sector protect bits packed into one register word
	always_comb begin
		prot_word = '0;
		for (int i = 0; i < 32; i++) begin
			if (i < NUM_SEC) begin
				prot_word[i] = s.prot[i];
			end
		end
	end

	// Byte enables widened to a bit mask
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			be_mask[b*8 +: 8] = {8{AV_BYTEENABLE[b]}};
		end
	end

	// Register read mux, sampled at the take edge
	always_comb begin
		case (AV_ADDRESS)
			fpd_pkg::REG_STATUS: begin
				reg_read = '0;
				reg_read[fpd_pkg::STATUS_MODE_LSB +: 2] = s.mode;
				reg_read[fpd_pkg::STATUS_LOCK_BIT] = s.lock;
			end
			fpd_pkg::REG_LOCK: begin
				reg_read = {31'h00000000, s.lock};
			end
			fpd_pkg::REG_TRAP: begin
				reg_read = s.trap;
			end
			fpd_pkg::REG_COUNT: begin
				reg_read = {16'h0000, s.count};
			end
			fpd_pkg::REG_UNIT_STS: begin
				reg_read = {16'h0000, s.unit_sts};
			end
			fpd_pkg::REG_PROT: begin
				reg_read = prot_word;
			end
			default: begin
				reg_read = 32'h00000000;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command sequencer
	always_comb begin
		n = s;
		n.req_s1 = req_tgl;
		n.req_s2 = s.req_s1;
		n.req_prev = s.req_s2;
		// Toggle back once per cycle; the link end waits for it
		if (new_cycle) begin
			n.ack_tgl = ~s.ack_tgl;
			n.rsp_data = idle_read;
			// Cycles for another die are answered but change nothing
			if (cap_die != DIE_SEL) begin
				n.rsp_data = 16'h0000;
			end else if (cap_code == fpd_pkg::CODE_WRITE) begin
				// Exit wins over any half-done sequence
				if (cap_wdata == fpd_pkg::DATA_EXIT) begin
					n.mode = fpd_pkg::MODE_NONE;
					n.seq = fpd_pkg::SEQ_IDLE;
				end else begin
					case (s.seq)
						fpd_pkg::SEQ_IDLE: begin
							// Start of an unlock, a program pair or a query
							if (cap_wdata == fpd_pkg::DATA_UNLOCK_1 &&
									low_addr == fpd_pkg::ADDR_UNLOCK_1) begin
								n.seq = fpd_pkg::SEQ_UNLK1;
							end else if (cap_wdata == fpd_pkg::DATA_PROG &&
									(s.mode == fpd_pkg::MODE_PLOCK ||
									s.mode == fpd_pkg::MODE_DPROT)) begin
								n.seq = fpd_pkg::SEQ_PROG;
							end else if (cap_wdata == fpd_pkg::DATA_QUERY) begin
								n.seq = fpd_pkg::SEQ_QUERY;
							end
						end
						fpd_pkg::SEQ_UNLK1: begin
							if (cap_wdata == fpd_pkg::DATA_UNLOCK_2 &&
									low_addr == fpd_pkg::ADDR_UNLOCK_2) begin
								n.seq = fpd_pkg::SEQ_UNLK2;
							end else begin
								n.seq = fpd_pkg::SEQ_IDLE;
							end
						end
						fpd_pkg::SEQ_UNLK2: begin
							// Third write picks the mode; a miss keeps the old one
							n.seq = fpd_pkg::SEQ_IDLE;
							if (low_addr == fpd_pkg::ADDR_UNLOCK_1) begin
								if (cap_wdata == fpd_pkg::DATA_PLOCK_ENT) begin
									n.mode = fpd_pkg::MODE_PLOCK;
								end else if (cap_wdata == fpd_pkg::DATA_DPROT_ENT) begin
									n.mode = fpd_pkg::MODE_DPROT;
								end else if (cap_wdata == fpd_pkg::DATA_ECC_ENT) begin
									n.mode = fpd_pkg::MODE_ECC;
								end
							end
						end
						fpd_pkg::SEQ_PROG: begin
							// Second write of a program pair
							n.seq = fpd_pkg::SEQ_IDLE;
							if (s.mode == fpd_pkg::MODE_PLOCK &&
									cap_wdata == fpd_pkg::DATA_ZERO) begin
								n.lock = 1'b0;
							end else if (s.mode == fpd_pkg::MODE_DPROT &&
									cap_wdata == fpd_pkg::DATA_ZERO) begin
								n.prot[sector] = 1'b0;
							end else if (s.mode == fpd_pkg::MODE_DPROT &&
									cap_wdata == fpd_pkg::DATA_ONE) begin
								n.prot[sector] = 1'b1;
							end
						end
						default: begin
							n.seq = fpd_pkg::SEQ_IDLE;
						end
					endcase
				end
			end else if (cap_code == fpd_pkg::CODE_READ) begin
				// A read always closes a sequence
				n.seq = fpd_pkg::SEQ_IDLE;
				if (s.seq == fpd_pkg::SEQ_QUERY) begin
					if (s.mode == fpd_pkg::MODE_ECC) begin
						case (cap_addr[1:0])
							fpd_pkg::SEL_TRAP_LOW: begin
								n.rsp_data = s.trap[15:0];
							end
							fpd_pkg::SEL_TRAP_HIGH: begin
								n.rsp_data = s.trap[31:16];
							end
							fpd_pkg::SEL_COUNT: begin
								n.rsp_data = s.count;
							end
							default: begin
								n.rsp_data = 16'h0000;
							end
						endcase
					end else begin
						n.rsp_data = status_word;
					end
				end
			end else begin
				n.seq = fpd_pkg::SEQ_IDLE;
				n.rsp_data = 16'h0000;
			end
		end

		// Avalon slave, one wait state on every access
		if (s.av_wait) begin
			if (AV_READ || AV_WRITE) begin
				n.av_wait = 1'b0;
				n.av_rdata = AV_READ ? reg_read : 32'h00000000;
			end
		end else begin
			n.av_wait = 1'b1;
			// Write lands on the edge after the wait ends, as waitrequest goes high again
			if (AV_WRITE) begin
				case (AV_ADDRESS)
					fpd_pkg::REG_LOCK: begin
						// Software set placed last so it wins over a link clear
						if (AV_BYTEENABLE[0] && AV_WRITEDATA[0]) begin
							n.lock = 1'b1;
						end
					end
					fpd_pkg::REG_TRAP: begin
						n.trap = (s.trap & ~be_mask) | (AV_WRITEDATA & be_mask);
					end
					fpd_pkg::REG_COUNT: begin
						n.count = (s.count & ~be_mask[15:0]) |
							(AV_WRITEDATA[15:0] & be_mask[15:0]);
					end
					fpd_pkg::REG_UNIT_STS: begin
						n.unit_sts = (s.unit_sts & ~be_mask[15:0]) |
							(AV_WRITEDATA[15:0] & be_mask[15:0]);
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Idle bus, no mode, all sectors protected after reset
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			s <= '{
				mode:     fpd_pkg::MODE_NONE,
				seq:      fpd_pkg::SEQ_IDLE,
				lock:     fpd_pkg::RST_LOCK,
				prot:     {NUM_SEC{fpd_pkg::RST_PROT}},
				trap:     fpd_pkg::RST_TRAP,
				count:    fpd_pkg::RST_COUNT,
				unit_sts: fpd_pkg::RST_UNIT_STS,
				av_wait:  1'b1,
				default:  '0
			};
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus outputs straight from the state flops
	assign AV_READDATA = s.av_rdata;
	assign AV_WAITREQUEST = s.av_wait;

endmodule

// File: tb/fpd_cmd_decoder_asserts.sv
`timescale 1ns/1ps
module fpd_cmd_decoder_asserts #(
	parameter logic [1:0] DIE_SEL = 2'h0
) (
	input wire logic        REF_CLK,
	input wire logic        RST,
	input wire logic        AV_READ,
	input wire logic        AV_WRITE,
	input wire logic        AV_WAITREQUEST,
	input wire logic        LINK_CLK,
	input wire logic        LINK_VALID,
	input wire logic [2:0]  LINK_CODE,
	input wire logic [1:0]  LINK_DIE,
	input wire logic        LINK_READY,
	input wire logic [15:0] LINK_RDATA,
	input wire logic        LINK_RVALID
);
	typedef struct packed {
		logic [2:0] code;
		logic [1:0] die;
	} fpd_seen_type;
	fpd_seen_type seen;
	fpd_seen_type next_seen;
	// Fields of the cycle last taken on the link
	always_comb begin
		next_seen = seen;
		if (LINK_VALID && LINK_READY)
			next_seen = {LINK_CODE, LINK_DIE};
	end
	always_ff @(posedge LINK_CLK or posedge RST) begin
		if (RST)
			seen <= '0;
		else
			seen <= next_seen;
	end
	////////////////////////////////////////////////////////////////
	sequence s_take;
		LINK_VALID && LINK_READY;
	endsequence
	sequence s_busy;
		!LINK_READY [*2];
	endsequence
	a_wait_once: assert property (@(posedge REF_CLK) disable iff (RST)
		(AV_READ || AV_WRITE) && AV_WAITREQUEST |=> !AV_WAITREQUEST)
		else $error("no answer after one wait cycle");
	a_wait_short: assert property (@(posedge REF_CLK) disable iff (RST)
		!AV_WAITREQUEST |=> AV_WAITREQUEST)
		else $error("waitrequest low too long");
	a_wait_idle: assert property (@(posedge REF_CLK) disable iff (RST)
		!AV_READ && !AV_WRITE |=> AV_WAITREQUEST)
		else $error("waitrequest low while idle");
	a_link_answer: assert property (@(posedge LINK_CLK) disable iff (RST)
		s_take |=> s_busy ##[1:6] LINK_READY)
		else $error("link answer out of time");
	a_rvalid_kind: assert property (@(posedge LINK_CLK) disable iff (RST)
		$rose(LINK_READY) |-> LINK_RVALID == (seen.code == fpd_pkg::CODE_READ))
		else $error("read valid does not match cycle type");
	a_rvalid_once: assert property (@(posedge LINK_CLK) disable iff (RST)
		LINK_RVALID |=> !LINK_RVALID)
		else $error("read valid longer than one cycle");
	a_rvalid_ready: assert property (@(posedge LINK_CLK) disable iff (RST)
		LINK_RVALID |-> $rose(LINK_READY))
		else $error("read valid without answer");
	a_die_zero: assert property (@(posedge LINK_CLK) disable iff (RST)
		LINK_RVALID && seen.die != DIE_SEL |-> LINK_RDATA == 16'h0000)
		else $error("other die read not zero");
	a_rdata_hold: assert property (@(posedge LINK_CLK) disable iff (RST)
		!$rose(LINK_READY) |-> $stable(LINK_RDATA))
		else $error("read word changed outside answer");
endmodule

bind fpd_cmd_decoder fpd_cmd_decoder_asserts #(.DIE_SEL(DIE_SEL)) fpd_cmd_decoder_asserts_i (
	.REF_CLK, .RST, .AV_READ, .AV_WRITE, .AV_WAITREQUEST, .LINK_CLK, .LINK_VALID,
	.LINK_CODE, .LINK_DIE, .LINK_READY, .LINK_RDATA, .LINK_RVALID);

// File: tb/fpd_host_model.sv
`timescale 1ns/1ps
module fpd_host_model #(
	parameter int ADDR_W = 22
) (
	output logic              link_clk,
	output logic              link_valid,
	output logic [2:0]        link_code,
	output logic [1:0]        link_die,
	output logic [ADDR_W-1:0] link_addr,
	output logic [7:0]        link_wdata,
	input  wire logic         link_ready,
	input  wire logic [15:0]  link_rdata,
	input  wire logic         link_rvalid
);
	logic run = 1'b1;
	initial begin
		link_clk = 1'b0;
		link_valid = 1'b0;
		link_code = 3'h0;
		link_die = 2'h0;
		link_addr = '0;
		link_wdata = 8'h00;
	end
	// Clock stands low between cycles
	always #40 link_clk = run ? ~link_clk : 1'b0;
	////////////////////////////////////////////////////////////////
	task automatic xfer(input logic [2:0] c, input logic [1:0] d, input logic [ADDR_W-1:0] a,
		input logic [7:0] w, input int gap, output logic [15:0] rd, output bit got,
		output bit ok);
		int n;
		run = 1'b1;
		got = 1'b0;
		rd = 16'h0000;
		repeat (gap + 1) @(posedge link_clk);
		link_valid <= 1'b1;
		link_code <= c;
		link_die <= d;
		link_addr <= a;
		link_wdata <= w;
		for (n = 0; n < 30; n++) begin
			@(posedge link_clk);
			if (link_ready === 1'b1)
				break;
		end
		ok = n < 30;
		// Released fields show the inverse of the last value
		link_valid <= 1'b0;
		link_code <= ~c;
		link_die <= ~d;
		link_addr <= ~a;
		link_wdata <= ~w;
		for (n = 0; n < 30; n++) begin
			@(posedge link_clk);
			if (link_rvalid === 1'b1) begin
				got = 1'b1;
				rd = link_rdata;
			end
			if (link_ready === 1'b1)
				break;
		end
		ok = ok && n < 30;
		run = 1'b0;
	endtask
endmodule

// File: tb/fpd_cmd_decoder_bench.sv
`timescale 1ns/1ps
module fpd_cmd_decoder_bench;
	localparam int         SEC_LSB = 17;
	localparam logic [1:0] DIE     = 2'h2;
	localparam logic [2:0] WR      = fpd_pkg::CODE_WRITE;
	localparam logic [2:0] RD      = fpd_pkg::CODE_READ;
	logic        REF_CLK       = 1'b0;
	logic        RST           = 1'b1;
	logic [7:0]  AV_ADDRESS    = 8'h00;
	logic        AV_READ       = 1'b0;
	logic        AV_WRITE      = 1'b0;
	logic [31:0] AV_WRITEDATA  = 32'h0;
	logic [3:0]  AV_BYTEENABLE = 4'h0;
	logic [31:0] AV_READDATA;
	logic        AV_WAITREQUEST;
	logic        LINK_CLK;
	logic        LINK_VALID;
	logic [2:0]  LINK_CODE;
	logic [1:0]  LINK_DIE;
	logic [21:0] LINK_ADDR;
	logic [7:0]  LINK_WDATA;
	logic        LINK_READY;
	logic [15:0] LINK_RDATA;
	logic        LINK_RVALID;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          seed       = 32'hF88628D4;
	int          sq         = 0;
	logic [1:0]  md         = 2'h0;
	logic        lk         = 1'b1;
	logic [31:0] prot       = 32'hFFFFFFFF;
	logic [31:0] trap       = 32'h0;
	logic [15:0] cnt        = 16'h0;
	logic [15:0] unit       = 16'h0;
	logic [21:0] a;
	always #12.5 REF_CLK = ~REF_CLK;
	fpd_cmd_decoder #(.ADDR_W(22), .SEC_LSB(SEC_LSB), .DIE_SEL(DIE)) fpd_cmd_decoder_i (
		.REF_CLK, .RST, .AV_ADDRESS, .AV_READ, .AV_WRITE, .AV_WRITEDATA, .AV_BYTEENABLE,
		.AV_READDATA, .AV_WAITREQUEST, .LINK_CLK, .LINK_VALID, .LINK_CODE, .LINK_DIE,
		.LINK_ADDR, .LINK_WDATA, .LINK_READY, .LINK_RDATA, .LINK_RVALID);
	fpd_host_model #(.ADDR_W(22)) fpd_host_model_i (
		.link_clk(LINK_CLK), .link_valid(LINK_VALID), .link_code(LINK_CODE),
		.link_die(LINK_DIE), .link_addr(LINK_ADDR), .link_wdata(LINK_WDATA),
		.link_ready(LINK_READY), .link_rdata(LINK_RDATA), .link_rvalid(LINK_RVALID));
	////////////////////////////////////////////////////////////////
	task automatic summarize();
		if (n_mismatch == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		num_checks++;
		if (got !== ex) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask
	function automatic logic [21:0] ra();
		ra = 22'($random(seed));
	endfunction
	// Expected answer of one link cycle, updating the device state
	function automatic logic [15:0] predict(input logic [2:0] c, input logic [1:0] d,
		input logic [21:0] ad, input logic [7:0] w);
		int s;
		int nsq;
		logic [63:0] q;
		s = ad[21:SEC_LSB];
		q = {16'h0, cnt, trap};
		predict = 16'h0;
		if (d != DIE)
			return predict;
		if (c == RD) begin
			if (sq == 4 && md == 2'h3)
				predict = q[16 * ad[1:0] +: 16];
			else if (sq == 4)
				predict = {14'h0, lk, prot[s]};
			else
				predict = md == 2'h0 ? 16'h0 : md == 2'h1 ? 16'(lk) : md == 2'h2 ? 16'(prot[s]) : unit;
			sq = 0;
		end else if (c != WR) begin
			sq = 0;
		end else begin
			nsq = 0;
			if (w == 8'hF0)
				md = 2'h0;
			else if (sq == 0 && w == 8'h60)
				nsq = 4;
			else if (sq == 0 && w == 8'hAA && ad[11:0] == 12'h555)
				nsq = 1;
			else if (sq == 1 && w == 8'h55 && ad[11:0] == 12'h2AA)
				nsq = 2;
			else if (sq == 2 && ad[11:0] == 12'h555 && w inside {8'h50, 8'hE0, 8'h75})
				md = w == 8'h50 ? 2'h1 : w == 8'hE0 ? 2'h2 : 2'h3;
			else if (sq == 0 && md inside {2'h1, 2'h2} && w == 8'hA0)
				nsq = 3;
			else if (sq == 3 && md == 2'h1 && w == 8'h00)
				lk = 1'b0;
			else if (sq == 3 && md == 2'h2 && w < 8'h02)
				prot[s] = w[0];
			sq = nsq;
		end
	endfunction
	task automatic av(input logic wr, input logic [7:0] ad, input logic [31:0] dt,
		input logic [3:0] be, output logic [31:0] rd);
		int n;
		@(posedge REF_CLK);
		AV_ADDRESS <= ad;
		AV_WRITEDATA <= dt;
		AV_BYTEENABLE <= be;
		AV_WRITE <= wr;
		AV_READ <= !wr;
		for (n = 0; n < 20; n++) begin
			@(posedge REF_CLK);
			if (AV_WAITREQUEST === 1'b0)
				break;
		end
		rd = AV_READDATA;
		AV_WRITE <= 1'b0;
		AV_READ <= 1'b0;
		if (n == 20) begin
			n_mismatch++;
			summarize();
		end
	endtask
	task automatic reg_wr(input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] be);
		logic [31:0] m;
		logic [31:0] r;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		av(1'b1, ad, dt, be, r);
		case (ad)
			fpd_pkg::REG_LOCK: lk = lk | (dt[0] & be[0]);
			fpd_pkg::REG_TRAP: trap = (trap & ~m) | (dt & m);
			fpd_pkg::REG_COUNT: cnt = (cnt & ~m[15:0]) | (dt[15:0] & m[15:0]);
			fpd_pkg::REG_UNIT_STS: unit = (unit & ~m[15:0]) | (dt[15:0] & m[15:0]);
			default: ;
		endcase
	endtask
	task automatic reg_rd(input logic [7:0] ad);
		logic [31:0] r;
		logic [31:0] e;
		case (ad)
			fpd_pkg::REG_STATUS: e = {29'h0, lk, md};
			fpd_pkg::REG_LOCK: e = {31'h0, lk};
			fpd_pkg::REG_TRAP: e = trap;
			fpd_pkg::REG_COUNT: e = {16'h0, cnt};
			fpd_pkg::REG_UNIT_STS: e = {16'h0, unit};
			fpd_pkg::REG_PROT: e = prot;
			default: e = 32'h0;
		endcase
		av(1'b0, ad, 32'h0, 4'hF, r);
		chk("readdata", e, r);
	endtask
	task automatic cyc(input logic [2:0] c, input logic [1:0] d, input logic [21:0] ad,
		input logic [7:0] w);
		logic [15:0] e;
		logic [15:0] r;
		logic        rdk;
		bit          got;
		bit          ok;
		rdk = c == RD;
		e = predict(c, d, ad, w);
		fpd_host_model_i.xfer(c, d, ad, w, $unsigned($random(seed)) % 3, r, got, ok);
		if (!ok) begin
			n_mismatch++;
			summarize();
		end
		chk("link_answer", {15'h0, rdk, e & {16{rdk}}}, {15'h0, got, r & {16{rdk}}});
	endtask
	task automatic enter(input logic [7:0] w);
		cyc(WR, DIE, {10'($random(seed)), 12'h555}, 8'hAA);
		cyc(WR, DIE, {10'($random(seed)), 12'h2AA}, 8'h55);
		cyc(WR, DIE, {10'($random(seed)), 12'h555}, w);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge REF_CLK);
		RST <= 1'b0;
		reg_wr(8'h20, 32'hFFFFFFFF, 4'hF);
		reg_wr(fpd_pkg::REG_STATUS, 32'hFFFFFFFF, 4'hF);
		reg_wr(fpd_pkg::REG_PROT, 32'h0, 4'hF);
		reg_wr(fpd_pkg::REG_TRAP, $random(seed), 4'hF);
		reg_wr(fpd_pkg::REG_TRAP, $random(seed), 4'h6);
		reg_wr(fpd_pkg::REG_COUNT, $random(seed), 4'hF);
		reg_wr(fpd_pkg::REG_UNIT_STS, $random(seed), 4'hF);
		for (int i = 0; i < 9; i++)
			reg_rd(8'(i * 4));
		cyc(RD, DIE, ra(), 8'h00);
		enter(8'h50);
		cyc(RD, DIE, ra(), 8'h00);
		cyc(WR, DIE, ra(), 8'hA0);
		cyc(WR, DIE, ra(), 8'h00);
		cyc(RD, DIE, ra(), 8'h00);
		reg_rd(fpd_pkg::REG_STATUS);
		reg_wr(fpd_pkg::REG_LOCK, 32'h1, 4'h1);
		cyc(RD, DIE, ra(), 8'h00);
		cyc(WR, DIE, ra(), 8'hF0);
		enter(8'hE0);
		for (int i = 0; i < 3; i++) begin
			a = ra();
			for (int j = 0; j < 2; j++) begin
				cyc(WR, DIE, ra(), 8'hA0);
				cyc(WR, DIE, a, 8'(j));
				cyc(RD, DIE, {a[21:SEC_LSB], 17'($random(seed))}, 8'h00);
				cyc(WR, DIE, ra(), 8'h60);
				cyc(RD, DIE, a, 8'h00);
				reg_rd(fpd_pkg::REG_PROT);
			end
		end
		cyc(WR, DIE, {10'h3FF, 12'h555}, 8'hAA);
		cyc(WR, DIE, {10'h000, 12'h2AA}, 8'h55);
		cyc(3'h3, DIE, ra(), 8'h00);
		cyc(WR, DIE, {10'h155, 12'h555}, 8'h75);
		cyc(WR, DIE, ra(), 8'hA0);
		cyc(RD, DIE, a, 8'h00);
		cyc(WR, DIE, a, 8'h00);
		cyc(RD, DIE ^ 2'h1, ra(), 8'h00);
		cyc(WR, DIE ^ 2'h3, ra(), 8'hF0);
		reg_rd(fpd_pkg::REG_STATUS);
		enter(8'h75);
		for (int i = 0; i < 4; i++) begin
			cyc(RD, DIE, ra(), 8'h00);
			cyc(WR, DIE, ra(), 8'h60);
			cyc(RD, DIE, {20'($random(seed)), 2'(i)}, 8'h00);
		end
		reg_rd(fpd_pkg::REG_STATUS);
		cyc(WR, DIE, ra(), 8'hF0);
		cyc(RD, DIE, ra(), 8'h00);
		reg_rd(fpd_pkg::REG_STATUS);
		summarize();
	end
endmodule
